//--- design/twecp_pkg.sv
// Constants, field layout and types for the three-wire EEPROM command port.
// Assumes a 25 MHz core clock; every other file but the link interface and the host model imports this package.
`default_nettype none
package twecp_pkg;
  // Array shape: 64 words of 16 bits, byte-addressable in 8-bit mode
  localparam int WORDS   = 64;
  localparam int WORD_AW = 6;
  localparam int WORD_W  = 16;
  localparam int BYTE_W  = 8;
  localparam int BE_W    = WORD_W / BYTE_W;
  localparam int AW8     = 7;
  localparam int AW16    = 6;
  localparam int OP_W    = 2;
  localparam int CNT_W   = 5;
  localparam int BYTE_SEL_POS = 0;

  // Header is opcode plus address; data length follows the width mode
  localparam logic [CNT_W-1:0] HDR8_LEN   = 5'h09;
  localparam logic [CNT_W-1:0] HDR16_LEN  = 5'h08;
  localparam logic [CNT_W-1:0] DATA8_LEN  = 5'h08;
  localparam logic [CNT_W-1:0] DATA16_LEN = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;

  localparam logic [OP_W-1:0] OP_MISC  = 2'h0;
  localparam logic [OP_W-1:0] OP_WRITE = 2'h1;
  localparam logic [OP_W-1:0] OP_READ  = 2'h2;
  localparam logic [OP_W-1:0] OP_ERASE = 2'h3;
  // Leading address bits that pick the sub-command under OP_MISC
  localparam logic [OP_W-1:0] SUB_DISABLE   = 2'h0;
  localparam logic [OP_W-1:0] SUB_FILL      = 2'h1;
  localparam logic [OP_W-1:0] SUB_ERASE_ALL = 2'h2;
  localparam logic [OP_W-1:0] SUB_ENABLE    = 2'h3;

  localparam logic [WORD_W-1:0] ERASED_WORD = 16'hFFFF;
  localparam logic [BE_W-1:0]   BE_ALL      = 2'h3;
  localparam logic [BE_W-1:0]   BE_HIGH     = 2'h2;
  localparam logic [BE_W-1:0]   BE_LOW      = 2'h1;
  localparam logic DUMMY_BIT  = 1'b0;
  localparam logic START_BIT  = 1'b1;

  // Pin order inside the synchroniser vector
  localparam int PIN_N   = 4;
  localparam int PIN_CS  = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_DIN = 2;
  localparam int PIN_ORG = 3;

  localparam int CLK_HZ        = 25_000_000;
  localparam int MS_PER_S      = 1000;
  localparam int PROG_TIME_MS  = 3;
  localparam int PROG_CYCLES   = PROG_TIME_MS * (CLK_HZ / MS_PER_S);

  typedef enum logic [2:0] {
    TWECP_HUNT  = 3'h0,
    TWECP_HEAD  = 3'h1,
    TWECP_DATA  = 3'h3,
    TWECP_FETCH = 3'h2,
    TWECP_RDOUT = 3'h6,
    TWECP_DONE  = 3'h7
  } twecp_state_e;
endpackage : twecp_pkg
`default_nettype wire

//--- design/twecp_link_if.sv
// Synchronised link levels and edge pulses, from the pin synchroniser
// to the command decoder. All signals live on the core clock.
`default_nettype none
interface twecp_link_if;
  logic cs;
  logic din;
  logic x16;
  logic cs_rise;
  logic cs_fall;
  logic sck_rise;
  modport src (output cs, din, x16, cs_rise, cs_fall, sck_rise);
  modport dst (input  cs, din, x16, cs_rise, cs_fall, sck_rise);
endinterface : twecp_link_if
`default_nettype wire

//--- design/twecp_mem.sv
// Word array with byte enables and a registered read port.
// Contents are not reset; a read shows data one clock after the address.
`default_nettype none
module twecp_mem
  import twecp_pkg::*;
#(
  parameter int AW = WORD_AW,
  parameter int DW = WORD_W
) (
  input  wire logic               ref_clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               we_in,
  input  wire logic [DW/BYTE_W-1:0] be_in,
  input  wire logic [AW-1:0]      addr_in,
  input  wire logic [DW-1:0]      wdata_in,
  output logic      [DW-1:0]      rdata_out
);
  logic [DW-1:0] cells [0:(1<<AW)-1];

  always_ff @(posedge ref_clk_in) begin
    for (int b = 0; b < DW/BYTE_W; b++) begin
      if (we_in && be_in[b]) begin
        cells[addr_in][b*BYTE_W +: BYTE_W] <= wdata_in[b*BYTE_W +: BYTE_W];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= cells[addr_in];
    end
  end
endmodule : twecp_mem
`default_nettype wire

//--- design/twecp_pin_sync.sv
// Two-flop synchronisers for the link pins plus edge pulses.
// The pins are asynchronous; edges are found on the second stage only.
`default_nettype none
module twecp_pin_sync
  import twecp_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  input  wire logic cs_pin_in,
  input  wire logic serial_clock_pin_in,
  input  wire logic serial_in_pin_in,
  input  wire logic width_select_pin_in,
  twecp_link_if.src link
);
  logic [PIN_N-1:0] meta;
  logic [PIN_N-1:0] stable;
  logic [PIN_N-1:0] prev;
  wire  [PIN_N-1:0] raw = {width_select_pin_in, serial_in_pin_in,
                           serial_clock_pin_in, cs_pin_in};

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta   <= '0;
      stable <= '0;
      prev   <= '0;
    end else begin
      meta   <= raw;
      stable <= meta;
      prev   <= stable;
    end
  end

  assign link.cs       = stable[PIN_CS];
  assign link.din      = stable[PIN_DIN];
  assign link.x16      = stable[PIN_ORG];
  assign link.cs_rise  = stable[PIN_CS] & ~prev[PIN_CS];
  assign link.cs_fall  = ~stable[PIN_CS] & prev[PIN_CS];
  assign link.sck_rise = stable[PIN_SCK] & ~prev[PIN_SCK];
endmodule : twecp_pin_sync
`default_nettype wire

//--- design/twecp_top.sv
// Command front end of a three-wire serial EEPROM: decoder, write latch,
// self-timed programming timer and read/status output driver.
// Assumes the link clock is slow enough to be sampled by the core clock.
`default_nettype none
module twecp_top
  import twecp_pkg::*;
#(
  parameter bit X16_ONLY      = 1'b0,
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  input  wire logic ref_clk_in,
  input  wire logic rst_n_in,
  input  wire logic cs_pin_in,
  input  wire logic serial_clock_pin_in,
  input  wire logic serial_in_pin_in,
  input  wire logic width_select_pin_in,
  output logic      serial_out_pin_out,
  output logic      serial_out_oe_n_out
);
  localparam int PCW = $clog2(PROG_CYCLES_P + 1);
  localparam logic [PCW-1:0] PROG_LAST = PCW'(PROG_CYCLES_P - 1);
  localparam logic [WORD_AW-1:0] LAST_WORD = WORD_AW'(WORDS - 1);

  twecp_link_if link ();

  twecp_state_e        state;
  twecp_state_e        next_state;
  logic [WORD_W-1:0]   shreg;
  logic [CNT_W-1:0]    bit_cnt;
  logic [OP_W-1:0]     cmd_op;
  logic [WORD_AW-1:0]  cmd_word;
  logic                cmd_byte;
  logic                wel;
  logic                busy;
  logic [PCW-1:0]      prog_cnt;
  logic                bulk_active;
  logic [WORD_AW-1:0]  bulk_idx;
  logic [WORD_W-1:0]   bulk_data;
  logic [WORD_W-1:0]   out_sh;
  logic [CNT_W-1:0]    out_left;
  logic                status_mode;
  logic                next_status;
  logic                next_do;
  logic                next_oe_n;
  logic [WORD_W-1:0]   mem_rdata;

  twecp_pin_sync u_sync (
    .ref_clk_in          (ref_clk_in),
    .rst_n_in            (rst_n_in),
    .cs_pin_in           (cs_pin_in),
    .serial_clock_pin_in (serial_clock_pin_in),
    .serial_in_pin_in    (serial_in_pin_in),
    .width_select_pin_in (width_select_pin_in),
    .link                (link)
  );

  wire x8 = !X16_ONLY && !link.x16;
  wire [CNT_W-1:0] hdr_len  = x8 ? HDR8_LEN : HDR16_LEN;
  wire [CNT_W-1:0] data_len = x8 ? DATA8_LEN : DATA16_LEN;

  // MSB-first shift on rising serial clock with select high
  wire bit_take = link.sck_rise && link.cs;
  wire [WORD_W-1:0] shifted = {shreg[WORD_W-2:0], link.din};

  // header fields of the collected bits
  wire [OP_W-1:0] hdr_op = x8 ? shreg[AW8+1 -: OP_W] : shreg[AW16+1 -: OP_W];
  wire [OP_W-1:0] hdr_sub = x8 ? shreg[AW8-1 -: OP_W]
                               : shreg[AW16-1 -: OP_W];
  wire [WORD_AW-1:0] hdr_word = x8 ? shreg[AW8-1 -: WORD_AW]
                                   : shreg[AW16-1 -: WORD_AW];
  wire hdr_byte = shreg[BYTE_SEL_POS];
  wire hdr_done = (state == TWECP_HEAD) && (bit_cnt == hdr_len);
  wire data_done = (state == TWECP_DATA) && (bit_cnt == data_len);
  wire misc_now = hdr_done && (hdr_op == OP_MISC);

  // start bit accepted only when idle and not programming
  wire start_taken = (state == TWECP_HUNT) && bit_take &&
                     (link.din == START_BIT) && !busy;
  // read decoded with no latch check
  wire rd_now     = hdr_done && (hdr_op == OP_READ);
  wire erase_now  = hdr_done && (hdr_op == OP_ERASE);
  wire erall_now  = misc_now && (hdr_sub == SUB_ERASE_ALL);
  wire enable_now = misc_now && (hdr_sub == SUB_ENABLE);
  wire disable_now = misc_now && (hdr_sub == SUB_DISABLE);
  // single write ends with its data
  wire wr_now     = data_done && (cmd_op == OP_WRITE);
  // fill all ends with its data
  wire fill_now   = data_done && (cmd_op == OP_MISC);
  wire to_data    = hdr_done && ((hdr_op == OP_WRITE) ||
                    (misc_now && (hdr_sub == SUB_FILL)));

  // programming only with the latch set
  wire prog_start = wel && (erase_now || erall_now || wr_now || fill_now);
  wire start_bulk = erall_now || fill_now;
  wire [WORD_W-1:0] in_data = x8 ? {BE_W{shreg[BYTE_W-1:0]}} : shreg;
  wire [WORD_W-1:0] start_data = (erase_now || erall_now) ? ERASED_WORD
                                                          : in_data;
  wire single_sel = erase_now ? hdr_byte : cmd_byte;
  wire [BE_W-1:0] single_be = !x8 ? BE_ALL : (single_sel ? BE_HIGH : BE_LOW);

  wire mem_we = (prog_start && !start_bulk) || bulk_active;
  wire [BE_W-1:0] mem_be = bulk_active ? BE_ALL : single_be;
  wire [WORD_W-1:0] mem_wdata = bulk_active ? bulk_data : start_data;
  wire [WORD_AW-1:0] mem_addr = bulk_active ? bulk_idx :
                                (state == TWECP_HEAD) ? hdr_word : cmd_word;
  wire [WORD_W-1:0] rd_word = !x8 ? mem_rdata :
       {(cmd_byte ? mem_rdata[WORD_W-1 -: BYTE_W]
                  : mem_rdata[BYTE_W-1:0]), {BYTE_W{1'b0}}};

  twecp_mem #(.AW(WORD_AW), .DW(WORD_W)) u_mem (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .we_in      (mem_we),
    .be_in      (mem_be),
    .addr_in    (mem_addr),
    .wdata_in   (mem_wdata),
    .rdata_out  (mem_rdata)
  );

  always_comb begin
    next_state = state;
    case (state)
      TWECP_HUNT:  if (start_taken) next_state = TWECP_HEAD;
      TWECP_HEAD: begin
        if (rd_now) next_state = TWECP_FETCH;
        else if (to_data) next_state = TWECP_DATA;
        else if (hdr_done) next_state = TWECP_DONE;
      end
      TWECP_DATA:  if (data_done) next_state = TWECP_DONE;
      TWECP_FETCH: next_state = TWECP_RDOUT;
      TWECP_RDOUT: begin
        if (bit_take && (out_left == CNT_ONE)) next_state = TWECP_DONE;
      end
      default:     next_state = state;
    endcase
    if (link.cs_fall) next_state = TWECP_HUNT;
  end

  // poll starts when select rises during programming
  assign next_status = (link.cs_rise && busy) ? 1'b1 :
                       (link.cs_fall || start_taken) ? 1'b0 : status_mode;

  always_comb begin
    next_do   = serial_out_pin_out;
    next_oe_n = serial_out_oe_n_out;
    if (link.cs_fall) begin
      next_oe_n = 1'b1;
      next_do   = 1'b0;
    end else if (next_status) begin
      // ready level is the inverse of busy
      next_oe_n = 1'b0;
      next_do   = !busy;
    end else if (rd_now) begin
      next_oe_n = 1'b0;
      next_do   = DUMMY_BIT;
    end else if ((state == TWECP_RDOUT) && bit_take) begin
      // next data bit on rising serial clock
      next_do   = out_sh[WORD_W-1];
    end else if (status_mode) begin
      next_oe_n = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state               <= TWECP_HUNT;
      status_mode         <= 1'b0;
      serial_out_pin_out  <= 1'b0;
      serial_out_oe_n_out <= 1'b1;
    end else begin
      state               <= next_state;
      status_mode         <= next_status;
      serial_out_pin_out  <= next_do;
      serial_out_oe_n_out <= next_oe_n;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shreg   <= '0;
      bit_cnt <= '0;
    end else if (start_taken || hdr_done) begin
      bit_cnt <= '0;
    end else if (bit_take) begin
      shreg   <= shifted;
      bit_cnt <= bit_cnt + CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_op   <= OP_MISC;
      cmd_word <= '0;
      cmd_byte <= 1'b0;
    end else if (hdr_done) begin
      cmd_op   <= hdr_op;
      cmd_word <= hdr_word;
      cmd_byte <= hdr_byte;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_sh   <= '0;
      out_left <= '0;
    end else if (state == TWECP_FETCH) begin
      out_sh   <= rd_word;
      out_left <= data_len;
    end else if ((state == TWECP_RDOUT) && bit_take) begin
      out_sh   <= {out_sh[WORD_W-2:0], 1'b0};
      out_left <= out_left - CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wel <= 1'b0;
    end else if (enable_now) begin
      wel <= 1'b1;
    end else if (disable_now) begin
      wel <= 1'b0;
    end
  end

  // timer starts on the cycle the last bit is decoded
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy     <= 1'b0;
      prog_cnt <= '0;
    end else if (prog_start) begin
      busy     <= 1'b1;
      prog_cnt <= PROG_LAST;
    end else if (busy) begin
      if (prog_cnt == '0) busy <= 1'b0;
      else prog_cnt <= prog_cnt - 1'b1;
    end
  end

  // Bulk commands sweep the array one word a clock inside the busy time
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bulk_active <= 1'b0;
      bulk_idx    <= '0;
      bulk_data   <= '0;
    end else if (prog_start && start_bulk) begin
      bulk_active <= 1'b1;
      bulk_idx    <= '0;
      bulk_data   <= start_data;
    end else if (bulk_active) begin
      bulk_idx    <= bulk_idx + 1'b1;
      if (bulk_idx == LAST_WORD) bulk_active <= 1'b0;
    end
  end

  property p_reset_idle;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !$past(rst_n_in) |-> (state == TWECP_HUNT) && serial_out_oe_n_out;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("decoder not idle after reset");

  property p_wel_reset;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !$past(rst_n_in) |-> !wel;
  endproperty
  a_wel_reset: assert property (p_wel_reset)
    else $error("write latch set after reset");

  property p_start;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (state == TWECP_HUNT) && bit_take && link.din && !busy && !link.cs_fall
      |=> state == TWECP_HEAD;
  endproperty
  a_start: assert property (p_start)
    else $error("start bit not taken");

  property p_refuse;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(busy) |-> $past(wel);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("programming started without latch");

  property p_wel_hold;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    wel && !disable_now |=> wel;
  endproperty
  a_wel_hold: assert property (p_wel_hold)
    else $error("write latch dropped");

  property p_dummy;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_now && !link.cs_fall |=>
      (!serial_out_pin_out && !serial_out_oe_n_out)[*2];
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("dummy bit missing");

  property p_shift_out;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (state == TWECP_RDOUT) && bit_take && !link.cs_fall && !status_mode
      |=> serial_out_pin_out == $past(out_sh[WORD_W-1]);
  endproperty
  a_shift_out: assert property (p_shift_out)
    else $error("read bit wrong");

  property p_read_any;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_now && !link.cs_fall |=> ##1 state == TWECP_RDOUT;
  endproperty
  a_read_any: assert property (p_read_any)
    else $error("read not executed");

  property p_status;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    status_mode && link.cs && !link.cs_fall && !start_taken
      |=> !serial_out_oe_n_out && (serial_out_pin_out == !$past(busy));
  endproperty
  a_status: assert property (p_status)
    else $error("status level wrong");

  property p_write_start;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_now && wel |=> busy && (prog_cnt == PROG_LAST);
  endproperty
  a_write_start: assert property (p_write_start)
    else $error("write cycle did not start");

  property p_erase_ones;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (erase_now && wel |-> mem_we && (mem_wdata == ERASED_WORD)) and
    (erall_now && wel |=> bulk_active && (bulk_data == ERASED_WORD));
  endproperty
  a_erase_ones: assert property (p_erase_ones)
    else $error("erase data not all ones");

  property p_cs_low;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    link.cs_fall |=> serial_out_oe_n_out && (state == TWECP_HUNT);
  endproperty
  a_cs_low: assert property (p_cs_low)
    else $error("select low not honoured");

  property p_c_read;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    (state == TWECP_RDOUT) ##1 (state == TWECP_DONE);
  endproperty
  c_read: cover property (p_c_read);

  property p_c_write;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_now && wel;
  endproperty
  c_write: cover property (p_c_write);

  property p_c_ready;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    status_mode && $fell(busy);
  endproperty
  c_ready: cover property (p_c_ready);
endmodule : twecp_top
`default_nettype wire

//--- verification/twecp_host_model.sv
// Host side of the three-wire link: framed bit transfers, select control.
// Assumes the core clock as input; pins change on its falling edge.
`default_nettype none
module twecp_host_model (
  input  wire logic clk_in,
  input  wire logic do_in,
  output logic      cs_out,
  output logic      sck_out,
  output logic      din_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_out = 1'b0;
    sck_out = 1'b0;
    din_out = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask : wt
  task automatic set_cs(input logic v);
    @(negedge clk_in);
    cs_out = v;
  endtask : set_cs
  // select rises, MSB first, rising clock
  task automatic frame(input int n, input logic [31:0] bits,
                       output logic [31:0] got);
    got = '0;
    set_cs(1'b1);
    wt(4);
    for (int i = n - 1; i >= 0; i--) begin
      din_out = bits[i];
      wt(4);
      got = {got[30:0], do_in};
      sck_out = 1'b1;
      wt(4);
      sck_out = 1'b0;
    end
    cs_out = 1'b0;
    // Idle data is inverted once after each frame so a stale level is never trusted
    din_out = ~din_out;
    wt(8);
  endtask : frame
endmodule : twecp_host_model
`default_nettype wire

//--- verification/test_three_wire_eeprom_command_port.sv
// Self-checking bench for the EEPROM command port with a word model.
// Assumes the host model drives select, clock and data in, the bench drives width select; reads are predicted.
`default_nettype none
module test_three_wire_eeprom_command_port;
  import twecp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG = 100;
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        wsel = 1'b1;
  logic        cs, sck, din, dout, oe_n;
  wire         do_w = oe_n ? ~dout : dout;
  int          n_mismatch = 0;
  int          total_checks = 0;
  logic [31:0] seed = 32'h59;
  logic [15:0] mem [WORDS];
  bit          wel = 1'b0;
  always #20 ref_clk_in = ~ref_clk_in;
  twecp_top #(.PROG_CYCLES_P(PROG)) dut_u (
    .ref_clk_in          (ref_clk_in),
    .rst_n_in            (rst_n_in),
    .cs_pin_in           (cs),
    .serial_clock_pin_in (sck),
    .serial_in_pin_in    (din),
    .width_select_pin_in (wsel),
    .serial_out_pin_out  (dout),
    .serial_out_oe_n_out (oe_n)
  );
  twecp_host_model host_u (
    .clk_in  (ref_clk_in),
    .do_in   (do_w),
    .cs_out  (cs),
    .sck_out (sck),
    .din_out (din)
  );
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] mk(input int w);
    return (32'h1 << w) - 1;
  endfunction : mk
  function automatic logic [6:0] sa(input logic [1:0] s);
    int al;
    al = wsel ? AW16 : AW8;
    return 7'((32'(s) << (al - 2)) | (rnd() & mk(al - 2)));
  endfunction : sa
  // A0 high picks the upper byte in byte mode
  function automatic logic [15:0] get(input logic [6:0] a);
    if (wsel)
      return mem[a[5:0]];
    return a[0] ? 16'(mem[a[6:1]][15:8]) : 16'(mem[a[6:1]][7:0]);
  endfunction : get
  task automatic put(input logic [6:0] a, input logic [15:0] d);
    if (wsel)
      mem[a[5:0]] = d;
    else if (a[0])
      mem[a[6:1]][15:8] = d[7:0];
    else
      mem[a[6:1]][7:0] = d[7:0];
  endtask : put
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic chk_data(input logic [16:0] got, input logic [16:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t read %h want %h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_pin(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t pin %b want %b", $time, got, exp);
    end
  endtask : chk_pin
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  // Select raised again after a programming instruction
  task automatic status(input bit busy);
    int k;
    host_u.set_cs(1'b1);
    host_u.wt(8);
    chk_pin(oe_n, !busy);
    if (busy) begin
      chk_pin(dout, 1'b0);
      for (k = 0; k < 300 && dout !== 1'b1; k++)
        host_u.wt(1);
      if (k == 300) begin
        n_mismatch++;
        end_of_test();
      end
      chk_pin(dout, 1'b1);
    end
    host_u.set_cs(1'b0);
    host_u.wt(8);
  endtask : status
  task automatic instr(input logic [1:0] op, input logic [6:0] a,
                       input logic [15:0] d);
    int          al, dw, dl;
    logic [31:0] bits, got;
    logic [1:0]  sub;
    bit          prog;
    al = wsel ? AW16 : AW8;
    dw = wsel ? WORD_W : BYTE_W;
    sub = 2'(a >> (al - 2));
    prog = 1'b0;
    dl = (op == OP_WRITE || (op == OP_MISC && sub == SUB_FILL)) ? dw : 0;
    if (op == OP_READ)
      dl = dw + 1;
    if (dl != dw)
      d = '0;
    bits = ((((32'h4 | 32'(op)) << al) | (32'(a) & mk(al))) << dl)
           | (32'(d) & mk(dw));
    host_u.frame(3 + al + dl, bits, got);
    case (op)
      OP_READ: begin
        chk_data(17'(got & mk(dw + 1)), {1'b0, get(a)});
        chk_pin(oe_n, 1'b1);
      end
      OP_WRITE: if (wel) begin
        put(a, d);
        prog = 1'b1;
      end
      OP_ERASE: if (wel) begin
        put(a, ERASED_WORD);
        prog = 1'b1;
      end
      default: begin
        if (sub == SUB_ENABLE || sub == SUB_DISABLE)
          wel = sub[0];
        else if (wel) begin
          prog = 1'b1;
          for (int i = 0; i < WORDS; i++)
            mem[i] = sub == SUB_FILL ? (wsel ? d : {2{d[7:0]}})
                                     : ERASED_WORD;
        end
      end
    endcase
    if (op != OP_READ && !(op == OP_MISC && sub[0] == sub[1]))
      status(prog);
  endtask : instr
  initial begin
    logic [6:0]  a;
    logic [31:0] got;
    repeat (4) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    host_u.wt(2500);
    instr(OP_WRITE, 7'(rnd()), 16'(rnd()));
    instr(OP_MISC, sa(SUB_ENABLE), '0);
    instr(OP_MISC, sa(SUB_ERASE_ALL), '0);
    repeat (3) instr(OP_READ, 7'(rnd()), '0);
    done("erase all");
    repeat (4) begin
      a = 7'(rnd());
      instr(OP_WRITE, a, 16'(rnd()));
      instr(OP_READ, a, '0);
    end
    instr(OP_MISC, sa(SUB_FILL), 16'(rnd()));
    instr(OP_READ, 7'(rnd()), '0);
    instr(OP_ERASE, a, '0);
    instr(OP_READ, a, '0);
    host_u.frame(12, 32'hA3F, got);
    chk_pin(oe_n, 1'b1);
    instr(OP_READ, 7'h07, '0);
    done("word mode");
    @(negedge ref_clk_in);
    wsel = 1'b0;
    repeat (3) begin
      a = 7'(rnd());
      instr(OP_WRITE, a, 16'(rnd()));
      instr(OP_READ, a, '0);
      instr(OP_READ, a ^ 7'h01, '0);
    end
    instr(OP_MISC, sa(SUB_FILL), 16'(rnd()));
    instr(OP_READ, 7'(rnd()), '0);
    instr(OP_MISC, sa(SUB_DISABLE), '0);
    instr(OP_ERASE, a, '0);
    instr(OP_READ, a, '0);
    done("byte mode");
    instr(OP_MISC, sa(SUB_ENABLE), '0);
    // Reset in mid-run must drop the write latch
    @(negedge ref_clk_in);
    rst_n_in = 1'b0;
    wel = 1'b0;
    host_u.wt(4);
    rst_n_in = 1'b1;
    host_u.wt(8);
    instr(OP_ERASE, a, '0);
    instr(OP_READ, a, '0);
    instr(OP_MISC, sa(SUB_DISABLE), '0);
    done("reset");
    end_of_test();
  end
endmodule : test_three_wire_eeprom_command_port
`default_nettype wire
